// ===== at_cc_pkg.sv
package at_cc_pkg;
   // ----------------------------------------
   // register indices (word address = index)
   // ----------------------------------------
   // five index bits: value low of the last channel sits at 17
   localparam logic [4:0] IDX_IRQ_ENABLE = 5'h00;
   localparam logic [4:0] IDX_IRQ_FLAGS = 5'h01;
   localparam logic [4:0] IDX_SET_POINT_HIGH = 5'h02;
   localparam logic [4:0] IDX_SET_POINT_LOW = 5'h03;
   localparam logic [4:0] IDX_ERROR_HIGH = 5'h04;
   localparam logic [4:0] IDX_ERROR_LOW = 5'h05;
   localparam logic [4:0] IDX_CONTROL_BASE = 5'h06;
   localparam logic [4:0] IDX_SOURCE_BASE = 5'h09;
   localparam logic [4:0] IDX_VALUE_HIGH_BASE = 5'h0c;
   localparam logic [4:0] IDX_VALUE_LOW_BASE = 5'h0f;
   localparam int ADDR_WIDTH = 7;
   localparam int WORD_SHIFT = 2;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int NUM_CHAN = 3;
   localparam int PHASE_WIDTH = 10;
   localparam int PERIOD_WIDTH = 15;
   localparam int ERROR_WIDTH = 16;
   localparam int SRC_WIDTH = 3;
   localparam int SRC_INPUTS = 8;
   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_OUT_POL_BIT = 4;
   localparam int CTL_EDGE_BIT = 3;
   localparam int CTL_MODE_BIT = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h99;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [SRC_WIDTH-1:0] SRC_PIN_CODE = 3'h0;
   localparam logic [7:0] SP_HIGH_MASK = 8'h7f;
   localparam logic [31:0] UNMAPPED_READ = 32'h0;
endpackage

// ===== at_cc_channel.sv
`timescale 1ns/10ps
module at_cc_channel
   import at_cc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_capture_mode,
   input wire logic i_edge_falling,
   input wire logic i_out_polarity,
   input wire logic i_capture_in,
   input wire logic [at_cc_pkg::PHASE_WIDTH-1:0] i_phase_count,
   input wire logic i_value_write,
   input wire logic [at_cc_pkg::PHASE_WIDTH-1:0] i_value_data,
   output logic [at_cc_pkg::PHASE_WIDTH-1:0] o_chan_value,
   output logic o_event,
   output logic o_pulse_out
);
   import at_cc_pkg::*;

   logic capture_prev_reg;
   logic compare_prev_reg;
   logic edge_seen;
   logic match_now;
   logic fire;

   // ----------------------------------------
   // edge and match detection
   // ----------------------------------------
   // edge history always tracks, so enabling mid-level gives no false edge
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         capture_prev_reg <= 1'b0;
      end else begin
         capture_prev_reg <= i_capture_in;
      end
   end

   assign edge_seen = i_edge_falling ? (capture_prev_reg & ~i_capture_in)
                                     : (~capture_prev_reg & i_capture_in); // [RULE11]
   assign match_now = (i_phase_count == o_chan_value); // [RULE10]

   // one event per match entry, not per cycle the phase sits still
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         compare_prev_reg <= 1'b0;
      end else begin
         compare_prev_reg <= match_now & i_enable & ~i_capture_mode;
      end
   end

   assign fire = i_enable & (i_capture_mode ? edge_seen
                             : (match_now & ~compare_prev_reg)); // [RULE8] [RULE12]

   // ----------------------------------------
   // value register
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_chan_value <= '0;
      end else if (i_enable && i_capture_mode && edge_seen) begin
         o_chan_value <= i_phase_count; // [RULE14] [RULE18]
      end else if (i_value_write && !i_capture_mode) begin
         o_chan_value <= i_value_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_event <= 1'b0;
      end else begin
         o_event <= fire;
      end
   end

   // output pulse is one cycle, level set by polarity
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pulse_out <= 1'b0;
      end else begin
         o_pulse_out <= fire ^ i_out_polarity; // [RULE9] [RULE10]
      end
   end
endmodule // at_cc_channel

// ===== angular_timer_capture_compare.sv
// How it works
// [RULE1] per-channel irq enables at bits 2..0
// [RULE2] capture sets flag, value readable
// [RULE3] compare match sets channel flag
// [RULE4] flags sticky until software writes one
// [RULE5] 15-bit set point, high 7 low 8
// [RULE6] high byte buffered until low write
// [RULE7] error equals period minus set point
// [RULE8] control bit 7 enables channel logic
// [RULE9] capture update pulses output, polarity bit 4
// [RULE10] phase equals value pulses output, polarity
// [RULE11] capture edge falling if bit 3 set
// [RULE12] control bit 0 selects capture mode
// [RULE13] set point high bit 7 reads zero
// [RULE14] 10-bit phase counter is captured, compared
// [RULE15] 15-bit measured period is the minuend
// [RULE16] 3-bit source select, zero picks pin
// [RULE17] combined irq from enabled set flags
// [RULE18] 10-bit value, captures only when enabled
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module angular_timer_capture_compare
   import at_cc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [at_cc_pkg::ADDR_WIDTH-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [at_cc_pkg::PHASE_WIDTH-1:0] i_phase_count,
   input wire logic [at_cc_pkg::PERIOD_WIDTH-1:0] i_measured_period,
   input wire logic [at_cc_pkg::NUM_CHAN-1:0] i_capture_pin,
   input wire logic [1:0] i_comparator_sync,
   input wire logic [3:0] i_logic_cell_out,
   input wire logic i_waveform_irq,
   output logic [at_cc_pkg::NUM_CHAN-1:0] o_chan_pulse_out,
   output logic o_irq
);
   import at_cc_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0] ctl_reg [NUM_CHAN];
   logic [SRC_WIDTH-1:0] src_reg [NUM_CHAN];
   logic [PHASE_WIDTH-1:0] chan_value [NUM_CHAN];
   logic [7:0] val_high_buf_reg [NUM_CHAN];
   logic [2:0] irq_en_reg;
   logic [2:0] irq_flag_reg;
   logic [2:0] irq_flag_next;
   logic [2:0] chan_event;
   logic [NUM_CHAN-1:0] chan_pulse;
   logic [6:0] sp_high_buf_reg;
   logic [PERIOD_WIDTH-1:0] set_point_reg;
   logic [ERROR_WIDTH-1:0] error_reg;
   logic [SRC_INPUTS-1:0] pin_meta_reg;
   logic [SRC_INPUTS-1:0] pin_sync_reg;
   logic [SRC_INPUTS-1:0] src_raw;
   logic [4:0] word_idx;
   logic wr_fire;
   logic rd_fire;
   logic ack_reg;
   logic lane0;
   logic [7:0] wdata;
   logic [31:0] read_mux;
   logic irq_next;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // one wait state: request answered on the edge after it is seen
   assign word_idx = i_avs_address[ADDR_WIDTH-1:WORD_SHIFT];
   assign lane0 = i_avs_byteenable[0];
   assign wdata = i_avs_writedata[7:0];
   assign wr_fire = i_avs_write & ack_reg & lane0;
   assign rd_fire = i_avs_read & ack_reg;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_reg);
      end
   end

   // ----------------------------------------
   // capture source synchroniser
   // ----------------------------------------
   // all sources treated as asynchronous; costs two cycles of latency
   assign src_raw = {i_waveform_irq, i_logic_cell_out, i_comparator_sync, 1'b0};

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= src_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------
   // channels
   // ----------------------------------------
   logic [NUM_CHAN-1:0] pin_meta_ch_reg;
   logic [NUM_CHAN-1:0] pin_sync_ch_reg;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta_ch_reg <= '0;
         pin_sync_ch_reg <= '0;
      end else begin
         pin_meta_ch_reg <= i_capture_pin;
         pin_sync_ch_reg <= pin_meta_ch_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_chan
         logic cap_in;
         logic val_wr;
         assign cap_in = (src_reg[g] == SRC_PIN_CODE) ? pin_sync_ch_reg[g]
                                                      : pin_sync_reg[src_reg[g]]; // [RULE16]
         assign val_wr = wr_fire && (word_idx == IDX_VALUE_LOW_BASE + 4'(g));

         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               ctl_reg[g] <= CTL_RESET;
            end else if (wr_fire && word_idx == IDX_CONTROL_BASE + 4'(g)) begin
               ctl_reg[g] <= wdata & CTL_WRITE_MASK;
            end
         end

         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               src_reg[g] <= SRC_PIN_CODE;
            end else if (wr_fire && word_idx == IDX_SOURCE_BASE + 4'(g)) begin
               src_reg[g] <= wdata[SRC_WIDTH-1:0];
            end
         end

         // compare value high byte waits for the low byte write
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               val_high_buf_reg[g] <= '0;
            end else if (wr_fire && word_idx == IDX_VALUE_HIGH_BASE + 4'(g)) begin
               val_high_buf_reg[g] <= wdata;
            end
         end

         at_cc_channel u_chan (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_enable(ctl_reg[g][CTL_ENABLE_BIT]), // [RULE8]
            .i_capture_mode(ctl_reg[g][CTL_MODE_BIT]), // [RULE12]
            .i_edge_falling(ctl_reg[g][CTL_EDGE_BIT]), // [RULE11]
            .i_out_polarity(ctl_reg[g][CTL_OUT_POL_BIT]),
            .i_capture_in(cap_in),
            .i_phase_count(i_phase_count),
            .i_value_write(val_wr),
            .i_value_data({val_high_buf_reg[g][1:0], wdata}),
            .o_chan_value(chan_value[g]),
            .o_event(chan_event[g]),
            .o_pulse_out(chan_pulse[g])
         );
      end
   endgenerate

   assign o_chan_pulse_out = chan_pulse;

   // ----------------------------------------
   // interrupt enables and flags
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_en_reg <= IRQ_RESET;
      end else if (wr_fire && word_idx == IDX_IRQ_ENABLE) begin
         irq_en_reg <= wdata[2:0]; // [RULE1]
      end
   end

   // write one clears; a new event in the same cycle wins
   always_comb begin
      irq_flag_next = irq_flag_reg;
      if (wr_fire && word_idx == IDX_IRQ_FLAGS) begin
         irq_flag_next = irq_flag_reg & ~wdata[2:0]; // [RULE4]
      end
      irq_flag_next = irq_flag_next | chan_event; // [RULE2] [RULE3]
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_flag_reg <= IRQ_RESET;
      end else begin
         irq_flag_reg <= irq_flag_next;
      end
   end

   assign irq_next = |(irq_flag_next & irq_en_reg);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_next; // [RULE17] [RULE1]
      end
   end

   // ----------------------------------------
   // set point and error
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_high_buf_reg <= '0;
      end else if (wr_fire && word_idx == IDX_SET_POINT_HIGH) begin
         sp_high_buf_reg <= wdata[6:0]; // [RULE6]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         set_point_reg <= '0;
      end else if (wr_fire && word_idx == IDX_SET_POINT_LOW) begin
         set_point_reg <= {sp_high_buf_reg, wdata}; // [RULE5] [RULE6]
      end
   end

   // registered so error readback is one cycle behind the period input
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         error_reg <= '0;
      end else begin
         error_reg <= {1'b0, i_measured_period} - {1'b0, set_point_reg}; // [RULE7] [RULE15]
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      read_mux = UNMAPPED_READ;
      case (word_idx)
         IDX_IRQ_ENABLE: read_mux[2:0] = irq_en_reg;
         IDX_IRQ_FLAGS: read_mux[2:0] = irq_flag_reg;
         IDX_SET_POINT_HIGH: read_mux[7:0] = {1'b0, set_point_reg[14:8]}; // [RULE13]
         IDX_SET_POINT_LOW: read_mux[7:0] = set_point_reg[7:0];
         IDX_ERROR_HIGH: read_mux[7:0] = error_reg[15:8]; // [RULE7]
         IDX_ERROR_LOW: read_mux[7:0] = error_reg[7:0];
         default: begin
            for (int c = 0; c < NUM_CHAN; c++) begin
               if (word_idx == IDX_CONTROL_BASE + 4'(c)) begin
                  read_mux[7:0] = ctl_reg[c];
               end
               if (word_idx == IDX_SOURCE_BASE + 4'(c)) begin
                  read_mux[SRC_WIDTH-1:0] = src_reg[c];
               end
               if (word_idx == IDX_VALUE_HIGH_BASE + 4'(c)) begin
                  read_mux[1:0] = chan_value[c][9:8]; // [RULE2]
               end
               if (word_idx == IDX_VALUE_LOW_BASE + 4'(c)) begin
                  read_mux[7:0] = chan_value[c][7:0];
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_avs_readdata <= '0;
      end else if ((i_avs_read | i_avs_write) && !ack_reg) begin
         o_avs_readdata <= i_avs_read ? read_mux : UNMAPPED_READ;
      end
   end
endmodule // angular_timer_capture_compare

// ===== at_cc_checker_asserts.sv
`timescale 1ns/10ps
module at_cc_checker
   import at_cc_pkg::*;
(
   input logic i_core_clk,
   input logic i_rst_n,
   input logic [at_cc_pkg::ADDR_WIDTH-1:0] i_avs_address,
   input logic i_avs_read,
   input logic i_avs_write,
   input logic [31:0] i_avs_writedata,
   input logic [3:0] i_avs_byteenable,
   input logic [31:0] o_avs_readdata,
   input logic o_avs_waitrequest,
   input logic [at_cc_pkg::PERIOD_WIDTH-1:0] i_measured_period,
   input logic [at_cc_pkg::NUM_CHAN-1:0] o_chan_pulse_out,
   input logic o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ------------------------------
   // shadow of software writes
   // ------------------------------
   logic [4:0] idx;
   logic wr_ack, rd_ack;
   logic [2:0] en_q, pol_q, en_c, act;
   logic [6:0] sp_buf;
   logic [14:0] sp_q;
   logic [7:0] ctl_q [3];
   logic [15:0] err_m;
   logic [29:0] spp;
   assign idx = i_avs_address[ADDR_WIDTH-1:WORD_SHIFT];
   assign wr_ack = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   assign rd_ack = i_avs_read && !o_avs_waitrequest;
   assign pol_q = {ctl_q[2][4], ctl_q[1][4], ctl_q[0][4]};
   assign en_c = {ctl_q[2][7], ctl_q[1][7], ctl_q[0][7]};
   // active cycles only, so a polarity flip is not mistaken for a pulse
   assign act = o_chan_pulse_out ^ pol_q;
   assign err_m = {1'b0, i_measured_period} - {1'b0, sp_q};
   assign spp = {sp_q, i_measured_period};
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_q <= 3'h0;
         sp_buf <= 7'h00;
         sp_q <= 15'h0000;
         ctl_q <= '{default: 8'h00};
      end else if (wr_ack) begin
         if (idx == IDX_IRQ_ENABLE) en_q <= i_avs_writedata[2:0];
         if (idx == IDX_SET_POINT_HIGH) sp_buf <= i_avs_writedata[6:0];
         if (idx == IDX_SET_POINT_LOW) sp_q <= {sp_buf, i_avs_writedata[7:0]};
         if (idx >= IDX_CONTROL_BASE && idx < IDX_SOURCE_BASE)
            ctl_q[2'(idx - IDX_CONTROL_BASE)] <= i_avs_writedata[7:0] & CTL_WRITE_MASK;
      end
   end
   // ------------------------------
   // assertions
   // ------------------------------
   answer_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer longer than one cycle");
   irq_masked_a: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !o_irq)
      else $error("irq raised with all enables clear");
   pulse_width_a: assert property (act != 3'h0 && pol_q == $past(pol_q)
      && pol_q == $past(pol_q, 2) |=> (act & $past(act)) == 3'h0)
      else $error("output pulse longer than one cycle");
   pulse_idle_a: assert property ((act & ~(en_c | $past(en_c) | $past(en_c, 2)
      | (pol_q ^ $past(pol_q)) | (pol_q ^ $past(pol_q, 2)))) == 3'h0)
      else $error("pulse on disabled channel");
   error_value_a: assert property (rd_ack
      && (idx == IDX_ERROR_HIGH || idx == IDX_ERROR_LOW)
      && $stable(spp) && spp == $past(spp, 2) && spp == $past(spp, 3)
      |-> o_avs_readdata[7:0] == (idx == IDX_ERROR_HIGH ? err_m[15:8] : err_m[7:0]))
      else $error("error value differs from period minus set point");
   read_zero_a: assert property (rd_ack |-> o_avs_readdata[31:8] == 24'h0
      && !(idx == IDX_SET_POINT_HIGH && o_avs_readdata[7]))
      else $error("unimplemented read bits not zero");
   ctl_readback_a: assert property (rd_ack && idx >= IDX_CONTROL_BASE
      && idx < IDX_SOURCE_BASE |-> o_avs_readdata[7:0] == ctl_q[2'(idx - IDX_CONTROL_BASE)])
      else $error("control readback wrong");
   cover property (o_irq);
   cover property (act != 3'h0);
   cover property (rd_ack && idx == IDX_ERROR_LOW);
endmodule // at_cc_checker

bind angular_timer_capture_compare at_cc_checker i_checker (
   .i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .i_measured_period(i_measured_period),
   .o_chan_pulse_out(o_chan_pulse_out),
   .o_irq(o_irq)
);

// ===== cc_far_model.sv
`timescale 1ns/10ps
module cc_far_model (
   input logic i_core_clk,
   input logic i_count_en,
   input logic i_set,
   input logic [3:0] i_line,
   input logic i_level,
   input logic [2:0] i_chan_pulse_out,
   output logic [2:0] o_capture_pin,
   output logic [1:0] o_comparator_sync,
   output logic [3:0] o_logic_cell_out,
   output logic o_waveform_irq,
   output logic [7:0] o_change_count
);
   // ------------------------------
   // source lines and output watch
   // ------------------------------
   // lines hold levels; each capture needs a real edge made by the bench
   logic [9:0] lines = 10'h000;
   logic [2:0] last_out = 3'h0;
   initial o_change_count = 8'h00;
   assign {o_waveform_irq, o_logic_cell_out, o_comparator_sync, o_capture_pin} = lines;
   always @(posedge i_core_clk) begin
      if (i_set) lines[i_line] <= i_level;
      last_out <= i_chan_pulse_out;
      if (i_count_en)
         o_change_count <= o_change_count + 8'($countones(last_out ^ i_chan_pulse_out));
   end
endmodule // cc_far_model

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
   import at_cc_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [6:0] address = 7'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic [9:0] phase = 10'h000;
   logic [14:0] period = 15'h0000;
   logic set = 1'b0;
   logic [3:0] line = 4'h0;
   logic level = 1'b0;
   logic [31:0] rdata;
   logic waitreq, wf, irq;
   logic [2:0] pin, pulse;
   logic [1:0] cmp;
   logic [3:0] lc;
   logic [7:0] changes, r;
   int errors = 0;
   int cmp_count = 0;
   int exp_chg = 0;
   always #10 i_core_clk = ~i_core_clk;
   angular_timer_capture_compare i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_phase_count(phase), .i_measured_period(period), .i_capture_pin(pin),
      .i_comparator_sync(cmp), .i_logic_cell_out(lc), .i_waveform_irq(wf),
      .o_chan_pulse_out(pulse), .o_irq(irq));
   cc_far_model i_far (.i_core_clk(i_core_clk), .i_count_en(i_rst_n), .i_set(set),
      .i_line(line), .i_level(level), .i_chan_pulse_out(pulse), .o_capture_pin(pin),
      .o_comparator_sync(cmp), .o_logic_cell_out(lc), .o_waveform_irq(wf),
      .o_change_count(changes));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic is_wr, input logic [4:0] idx, input logic [7:0] d);
      @(posedge i_core_clk);
      address <= {idx, 2'b00};
      wr <= is_wr;
      rd <= !is_wr;
      wdata <= {24'h0, d};
      do @(posedge i_core_clk); while (waitreq !== 1'b0);
      r = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [4:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(nm, r, exp);
   endtask
   task automatic drive(input logic [3:0] ln, input logic lv);
      @(posedge i_core_clk);
      set <= 1'b1;
      line <= ln;
      level <= lv;
      @(posedge i_core_clk);
      set <= 1'b0;
      repeat (8) @(posedge i_core_clk);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_core_clk);
      errors++;
      print_verdict();
   end
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      rd_chk("irq enable", IDX_IRQ_ENABLE, 8'h00);
      rd_chk("irq flags", IDX_IRQ_FLAGS, 8'h00);
      rd_chk("control", IDX_CONTROL_BASE, 8'h00);
      $display("test reset done");
      period <= 15'h7fff;
      bus(1'b1, IDX_SET_POINT_HIGH, 8'hff);
      rd_chk("err high early", IDX_ERROR_HIGH, 8'h7f);
      be <= 4'he;
      bus(1'b1, IDX_SET_POINT_LOW, 8'h55);
      be <= 4'hf;
      rd_chk("err high held", IDX_ERROR_HIGH, 8'h7f);
      bus(1'b1, IDX_SET_POINT_LOW, 8'h00);
      rd_chk("err low", IDX_ERROR_LOW, 8'hff);
      rd_chk("err high", IDX_ERROR_HIGH, 8'h00);
      rd_chk("sp high", IDX_SET_POINT_HIGH, 8'h7f);
      period <= 15'h0000;
      rd_chk("neg err high", IDX_ERROR_HIGH, 8'h81);
      rd_chk("neg err low", IDX_ERROR_LOW, 8'h00);
      $display("test set point done");
      bus(1'b1, IDX_IRQ_ENABLE, 8'h07);
      bus(1'b1, IDX_CONTROL_BASE, 8'h81);
      for (int k = 0; k < SRC_INPUTS; k++) begin
         bus(1'b1, IDX_SOURCE_BASE, 8'(k));
         phase <= 10'h2a0 + 10'(k);
         drive(k == 0 ? 4'h0 : 4'(k + 2), 1'b1);
         exp_chg += 2;
         rd_chk("cap flag", IDX_IRQ_FLAGS, 8'h01);
         check("irq", {7'h0, irq}, 8'h01);
         rd_chk("cap high", IDX_VALUE_HIGH_BASE, 8'h02);
         rd_chk("cap low", IDX_VALUE_LOW_BASE, 8'ha0 + 8'(k));
         bus(1'b1, IDX_IRQ_FLAGS, 8'h01);
         drive(k == 0 ? 4'h0 : 4'(k + 2), 1'b0);
         rd_chk("no fall cap", IDX_IRQ_FLAGS, 8'h00);
      end
      bus(1'b1, IDX_SOURCE_BASE, 8'h00);
      bus(1'b1, IDX_CONTROL_BASE, 8'h89);
      phase <= 10'h155;
      drive(4'h0, 1'b1);
      rd_chk("rise ignored", IDX_IRQ_FLAGS, 8'h00);
      drive(4'h0, 1'b0);
      exp_chg += 2;
      rd_chk("fall cap", IDX_IRQ_FLAGS, 8'h01);
      rd_chk("fall value", IDX_VALUE_LOW_BASE, 8'h55);
      rd_chk("sticky", IDX_IRQ_FLAGS, 8'h01);
      bus(1'b1, IDX_IRQ_FLAGS, 8'h01);
      $display("test capture done");
      // active low: idle level flips once, then pulses go low
      bus(1'b1, IDX_CONTROL_BASE, 8'h91);
      exp_chg += 1;
      repeat (2) @(posedge i_core_clk);
      check("idle level", {7'h0, pulse[0]}, 8'h01);
      drive(4'h0, 1'b1);
      exp_chg += 2;
      bus(1'b1, IDX_IRQ_FLAGS, 8'h01);
      bus(1'b1, IDX_CONTROL_BASE, 8'h11);
      phase <= 10'h3ff;
      drive(4'h0, 1'b0);
      drive(4'h0, 1'b1);
      rd_chk("disabled flag", IDX_IRQ_FLAGS, 8'h00);
      rd_chk("disabled value", IDX_VALUE_LOW_BASE, 8'h55);
      bus(1'b1, IDX_IRQ_ENABLE, 8'h00);
      bus(1'b1, IDX_CONTROL_BASE, 8'h81);
      drive(4'h0, 1'b0);
      drive(4'h0, 1'b1);
      exp_chg += 3;
      rd_chk("masked flag", IDX_IRQ_FLAGS, 8'h01);
      check("masked irq", {7'h0, irq}, 8'h00);
      bus(1'b1, IDX_IRQ_ENABLE, 8'h01);
      repeat (2) @(posedge i_core_clk);
      check("unmasked irq", {7'h0, irq}, 8'h01);
      bus(1'b1, IDX_IRQ_FLAGS, 8'h01);
      repeat (2) @(posedge i_core_clk);
      check("cleared irq", {7'h0, irq}, 8'h00);
      $display("test polarity and mask done");
      phase <= 10'h100;
      bus(1'b1, IDX_CONTROL_BASE, 8'h88);
      bus(1'b1, IDX_VALUE_HIGH_BASE, 8'h01);
      bus(1'b1, IDX_VALUE_LOW_BASE, 8'h23);
      rd_chk("cmp idle", IDX_IRQ_FLAGS, 8'h00);
      phase <= 10'h123;
      repeat (4) @(posedge i_core_clk);
      exp_chg += 2;
      rd_chk("cmp flag", IDX_IRQ_FLAGS, 8'h01);
      rd_chk("cmp value", IDX_VALUE_LOW_BASE, 8'h23);
      bus(1'b1, IDX_CONTROL_BASE + 4'h1, 8'h80);
      bus(1'b1, IDX_CONTROL_BASE + 4'h2, 8'h80);
      bus(1'b1, IDX_IRQ_ENABLE, 8'h07);
      phase <= 10'h000;
      repeat (4) @(posedge i_core_clk);
      exp_chg += 4;
      rd_chk("all flags", IDX_IRQ_FLAGS, 8'h07);
      rd_chk("enables", IDX_IRQ_ENABLE, 8'h07);
      bus(1'b1, IDX_IRQ_FLAGS, 8'h06);
      rd_chk("partial clear", IDX_IRQ_FLAGS, 8'h01);
      check("pulse changes", changes, 8'(exp_chg));
      $display("test compare done");
      print_verdict();
   end
endmodule // testbench
